// ==== core/sbtc_pkg.sv ====
// Constants for the sixteen-bit timer/counter block
package sbtc_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CNT_LO = 8'h00;
  localparam logic [7:0] ADDR_CNT_HI = 8'h04;
  localparam logic [7:0] ADDR_FLAG   = 8'h08;
  localparam logic [7:0] ADDR_CLR    = 8'h0C;
  localparam logic [7:0] ADDR_CTRL   = 8'h10;
  localparam logic [7:0] ADDR_EN     = 8'h14;
  // Control field positions
  localparam int CTRL_ON     = 0;
  localparam int CTRL_CS     = 1;
  localparam int CTRL_NOSYNC = 2;
  localparam int CTRL_OSCEN  = 3;
  localparam int CTRL_PS_LO  = 4;
  localparam int CTRL_PS_HI  = 5;
  localparam logic [7:0] CTRL_MASK = 8'h3F;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  // Instruction cycle is oscillator / 4
  localparam int OSCILLATOR_FREQUENCY_PER_INSN = 4;
  localparam logic [1:0] INSN_LAST = 2'(OSCILLATOR_FREQUENCY_PER_INSN - 1);
  localparam logic [1:0] PIN_ALL_IN = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Low bits of the prescaler that must be all ones for one output tick
  function automatic logic [2:0] ps_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    ps_mask = 3'h0;
      2'h1:    ps_mask = 3'h1;
      2'h2:    ps_mask = 3'h3;
      default: ps_mask = 3'h7;
    endcase
  endfunction
endpackage

// ==== core/sbtc_top.sv ====
// Sixteen-bit timer/counter with prescaler, overflow interrupt and AXI4-Lite registers
`timescale 1ns/1ps
module sbtc_top (
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [7:0]  ARADDR,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  input  wire logic        EXTERNAL_COUNT_INPUT,
  input  wire logic        OSC_INPUT_PIN,
  input  wire logic        CCP_TIMER_RESET,
  input  wire logic        SLEEP_MODE,
  input  wire logic [1:0]  PORT_B_DIRECTION,
  output logic [1:0]       PIN_DIRECTION,
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus state
  logic        aw_got_ff, nxt_aw_got;
  logic        w_got_ff, nxt_w_got;
  logic [7:0]  awaddr_ff, nxt_awaddr;
  logic [7:0]  wdata_ff, nxt_wdata;
  logic        wstrb_ff, nxt_wstrb;
  logic        awready_ff, nxt_awready;
  logic        wready_ff, nxt_wready;
  logic        bvalid_ff, nxt_bvalid;
  logic [1:0]  bresp_ff, nxt_bresp;
  logic        arready_ff, nxt_arready;
  logic        rvalid_ff, nxt_rvalid;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic [1:0]  rresp_ff, nxt_rresp;
  logic        wr_go;
  logic        wr_ok;
  // Timer state
  logic [15:0] cnt_ff, nxt_cnt;
  logic [7:0]  ctrl_ff, nxt_ctrl;
  logic        flag_ff, nxt_flag;
  logic        en_ff, nxt_en;
  logic        irq_ff, nxt_irq;
  logic [1:0]  pdir_ff, nxt_pdir;
  logic [1:0]  insn_ff, nxt_insn;
  logic [2:0]  psc_ff, nxt_psc;
  logic        src_prev_ff, nxt_src_prev;
  logic        sync1_ff, nxt_sync1;
  logic        sync2_ff, nxt_sync2;
  logic        src_pin, ev, psc_tick, inc, cnt_on, cs, nosync;
  logic        wr_lo, wr_hi, clr_wr;

  // Address decode shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == sbtc_pkg::ADDR_CNT_LO) || (a == sbtc_pkg::ADDR_CNT_HI) ||
             (a == sbtc_pkg::ADDR_FLAG) || (a == sbtc_pkg::ADDR_CLR) ||
             (a == sbtc_pkg::ADDR_CTRL) || (a == sbtc_pkg::ADDR_EN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data taken in either order, one at a time
  assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_ok = wr_go && wstrb_ff && mapped(awaddr_ff);

  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_w_got  = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    if (AWVALID && awready_ff) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = AWADDR;
    end
    if (WVALID && wready_ff) begin
      nxt_w_got = 1'b1;
      nxt_wdata = WDATA[7:0];  // Registers are a byte wide
      nxt_wstrb = WSTRB[0];
    end
    if (wr_go) begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = mapped(awaddr_ff) ? sbtc_pkg::RESP_OKAY : sbtc_pkg::RESP_SLVERR;
    end else if (bvalid_ff && BREADY) begin
      nxt_bvalid = 1'b0;
    end
    nxt_awready = !nxt_aw_got && !nxt_bvalid;
    nxt_wready  = !nxt_w_got && !nxt_bvalid;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (ARVALID && arready_ff) begin
      nxt_rvalid  = 1'b1;
      nxt_rresp   = mapped(ARADDR) ? sbtc_pkg::RESP_OKAY : sbtc_pkg::RESP_SLVERR;
      case (ARADDR)
        sbtc_pkg::ADDR_CNT_LO: nxt_rdata = cnt_ff[7:0];
        sbtc_pkg::ADDR_CNT_HI: nxt_rdata = cnt_ff[15:8];
        sbtc_pkg::ADDR_FLAG:   nxt_rdata = {7'h00, flag_ff};
        sbtc_pkg::ADDR_CTRL:   nxt_rdata = ctrl_ff;
        sbtc_pkg::ADDR_EN:     nxt_rdata = {7'h00, en_ff};
        default:               nxt_rdata = 8'h00;
      endcase
    end else if (rvalid_ff && RREADY) begin
      nxt_rvalid  = 1'b0;
    end
    // Address channel open whenever no read answer is pending, so it opens after reset
    nxt_arready = !nxt_rvalid;
  end

  // Bus registers
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 8'h00;
      wstrb_ff   <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 8'h00;
      rresp_ff   <= 2'h0;
    end else begin
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      awaddr_ff  <= nxt_awaddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  assign AWREADY = awready_ff;
  assign WREADY  = wready_ff;
  assign BVALID  = bvalid_ff;
  assign BRESP   = bresp_ff;
  assign ARREADY = arready_ff;
  assign RVALID  = rvalid_ff;
  assign RDATA   = {24'h000000, rdata_ff};
  assign RRESP   = rresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Clock source, prescaler and count
  assign cnt_on = ctrl_ff[sbtc_pkg::CTRL_ON];
  assign cs     = ctrl_ff[sbtc_pkg::CTRL_CS];
  assign nosync = ctrl_ff[sbtc_pkg::CTRL_NOSYNC];
  assign src_pin = ctrl_ff[sbtc_pkg::CTRL_OSCEN] ? OSC_INPUT_PIN
                                                 : EXTERNAL_COUNT_INPUT;
  // Source event: pin rising edge or instruction tick
  assign ev = cs ? (src_pin && !src_prev_ff)
                 : (insn_ff == sbtc_pkg::INSN_LAST);
  assign psc_tick = ev && cnt_on && ((psc_ff & sbtc_pkg::ps_mask(
                    ctrl_ff[sbtc_pkg::CTRL_PS_HI:sbtc_pkg::CTRL_PS_LO]))
                    == sbtc_pkg::ps_mask(
                    ctrl_ff[sbtc_pkg::CTRL_PS_HI:sbtc_pkg::CTRL_PS_LO]));
  // Synchronised path costs two cycles; sleep stops only the synchronised count, not the prescaler
  assign inc = cnt_on && ((!cs || nosync) ? psc_tick
                                          : (sync2_ff && !SLEEP_MODE));
  assign wr_lo  = wr_ok && (awaddr_ff == sbtc_pkg::ADDR_CNT_LO);
  assign wr_hi  = wr_ok && (awaddr_ff == sbtc_pkg::ADDR_CNT_HI);
  assign clr_wr = wr_ok && (awaddr_ff == sbtc_pkg::ADDR_CLR) && wdata_ff[0];

  always_comb begin
    nxt_insn     = insn_ff + 2'h1;
    nxt_src_prev = src_pin;
    nxt_psc      = (ev && cnt_on) ? psc_ff + 3'h1 : psc_ff;
    nxt_sync1    = psc_tick && cs && !nosync;
    nxt_sync2    = sync1_ff;
    nxt_cnt      = cnt_ff;
    if (CCP_TIMER_RESET) begin
      nxt_cnt = sbtc_pkg::CNT_RST;
    end else if (wr_lo) begin
      nxt_cnt = {cnt_ff[15:8], wdata_ff};
    end else if (wr_hi) begin
      nxt_cnt = {wdata_ff, cnt_ff[7:0]};
    end else if (inc) begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
    // Set wins over a simultaneous clear
    nxt_flag = (flag_ff && !clr_wr) || (inc && !CCP_TIMER_RESET && !wr_lo && !wr_hi &&
               (cnt_ff == sbtc_pkg::CNT_MAX));
    nxt_ctrl = (wr_ok && awaddr_ff == sbtc_pkg::ADDR_CTRL) ?
               (wdata_ff & sbtc_pkg::CTRL_MASK) : ctrl_ff;
    nxt_en   = (wr_ok && awaddr_ff == sbtc_pkg::ADDR_EN) ? wdata_ff[0] : en_ff;
    nxt_irq  = nxt_flag && nxt_en;
    nxt_pdir = nxt_ctrl[sbtc_pkg::CTRL_OSCEN] ? sbtc_pkg::PIN_ALL_IN
                                              : PORT_B_DIRECTION;
  end

  // Timer registers
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      insn_ff     <= 2'h0;
      src_prev_ff <= 1'b0;
      psc_ff      <= 3'h0;
      sync1_ff    <= 1'b0;
      sync2_ff    <= 1'b0;
      cnt_ff      <= sbtc_pkg::CNT_RST;
      flag_ff     <= 1'b0;
      ctrl_ff     <= sbtc_pkg::CTRL_RST;
      en_ff       <= 1'b0;
      irq_ff      <= 1'b0;
      pdir_ff     <= 2'h0;
    end else begin
      insn_ff     <= nxt_insn;
      src_prev_ff <= nxt_src_prev;
      psc_ff      <= nxt_psc;
      sync1_ff    <= nxt_sync1;
      sync2_ff    <= nxt_sync2;
      cnt_ff      <= nxt_cnt;
      flag_ff     <= nxt_flag;
      ctrl_ff     <= nxt_ctrl;
      en_ff       <= nxt_en;
      irq_ff      <= nxt_irq;
      pdir_ff     <= nxt_pdir;
    end
  end

  assign IRQ           = irq_ff;
  assign PIN_DIRECTION = pdir_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  cnt_wrap_a: assert property (
    inc && !CCP_TIMER_RESET && !wr_lo && !wr_hi && cnt_ff == 16'hFFFF
    |=> cnt_ff == 16'h0000 && flag_ff)
    else $error("count did not wrap with flag");
  flag_sticky_a: assert property (
    flag_ff && !clr_wr |=> flag_ff)
    else $error("overflow flag lost");
  irq_gate_a: assert property (
    IRQ == (flag_ff && en_ff))
    else $error("interrupt not gated by enable");
  stop_hold_a: assert property (
    !cnt_on && !CCP_TIMER_RESET && !wr_lo && !wr_hi |=> $stable(cnt_ff))
    else $error("count moved while stopped");
  timer_rate_a: assert property (
    cnt_on && !cs && !CCP_TIMER_RESET && !wr_lo && !wr_hi && insn_ff != 2'h3
    |=> $stable(cnt_ff))
    else $error("timer advanced off instruction tick");
  ccp_clear_a: assert property (
    CCP_TIMER_RESET |=> cnt_ff == 16'h0000)
    else $error("reset input did not clear count");
  osc_pins_a: assert property (
    nxt_ctrl[3] |=> PIN_DIRECTION == 2'h3)
    else $error("oscillator pins not forced to input");
  prescale_div_a: assert property (
    inc && !cs |-> (psc_ff & sbtc_pkg::ps_mask(ctrl_ff[5:4])) == sbtc_pkg::ps_mask(ctrl_ff[5:4]))
    else $error("prescaler ratio wrong");
  sync_delay_a: assert property (
    psc_tick && cs && !nosync ##1 (ctrl_ff[2:1] == 2'h1) |=> sync2_ff)
    else $error("synchroniser delay wrong");
  sleep_hold_a: assert property (
    cnt_on && cs && !nosync && SLEEP_MODE && !CCP_TIMER_RESET && !wr_lo && !wr_hi
    |=> $stable(cnt_ff))
    else $error("count moved in sleep");
  bus_resp_a: assert property (
    wr_go |=> BVALID && !AWREADY && !WREADY)
    else $error("write response missing");
  read_resp_a: assert property (
    ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read response missing");
endmodule

// ==== verif/sbtc_pulse_src.sv ====
// Pulse source for the external count and oscillator input pins
`timescale 1ns/1ps
module sbtc_pulse_src (
  input  wire logic clk,
  output logic      ext_pin,
  output logic      osc_pin
);
  ////////////////////////////////////////
  // Both pins rest low between bursts, so no stray edge is counted
  initial begin
    ext_pin = 1'b0;
    osc_pin = 1'b0;
  end
  // n rising edges on one pin; hp sets the half period, fast or slow
  task automatic burst(input logic sel_osc, input int n, input int hp);
    for (int i = 0; i < n; i++) begin
      repeat (hp) @(posedge clk);
      if (sel_osc) osc_pin <= 1'b1;
      else ext_pin <= 1'b1;
      repeat (hp) @(posedge clk);
      if (sel_osc) osc_pin <= 1'b0;
      else ext_pin <= 1'b0;
    end
  endtask
endmodule

// ==== verif/sbtc_tb_top.sv ====
// Self-checking testbench for the sixteen-bit timer/counter
`timescale 1ns/1ps
module sbtc_tb_top;
  logic        mclk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq, ccp, sleep, ext_pin, osc_pin;
  logic [7:0]  awaddr, araddr, e;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, pbdir, pdir, r;
  int          n_mismatch, checked;

  sbtc_pulse_src u_src (.clk(mclk), .ext_pin(ext_pin), .osc_pin(osc_pin));
  sbtc_top u_dut (
    .MCLK(mclk), .RESETN(resetn), .AWVALID(awvalid), .AWREADY(awready),
    .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
    .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
    .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready),
    .RDATA(rdata), .RRESP(rresp), .EXTERNAL_COUNT_INPUT(ext_pin),
    .OSC_INPUT_PIN(osc_pin), .CCP_TIMER_RESET(ccp), .SLEEP_MODE(sleep),
    .PORT_B_DIRECTION(pbdir), .PIN_DIRECTION(pdir), .IRQ(irq));

  ////////////////////////////////////////
  // Compare and count; unknowns never match
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, m, g, x);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] er = sbtc_pkg::RESP_OKAY);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge mclk);
      ta = ta | (awvalid & awready);
      tw = tw | (wvalid & wready);
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge mclk); while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er), "bresp");
    @(posedge mclk);
    bready <= 1'b0;
  endtask
  // Read: answer captured while it stands, before the closing edge
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge mclk); while (arready !== 1'b1);
    @(posedge mclk);
    arvalid <= 1'b0;
    do @(negedge mclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge mclk);
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x, input string m);
    rd(a);
    chk(d, x, m);
    chk(32'(r), 32'(sbtc_pkg::RESP_OKAY), "rresp");
  endtask
  // Pin checks read the output at the falling edge, where it has settled
  task automatic pchk(input logic sel_irq, input logic [1:0] x, input string m);
    @(negedge mclk);
    chk(sel_irq ? 32'(irq) : 32'(pdir), 32'(x), m);
  endtask

  ////////////////////////////////////////
  task automatic t_regs;
    rc(sbtc_pkg::ADDR_CNT_LO, 32'h0, "lo rst");
    rc(sbtc_pkg::ADDR_CTRL, 32'h0, "ctrl rst");
    rc(sbtc_pkg::ADDR_EN, 32'h0, "en rst");
    wr(sbtc_pkg::ADDR_FLAG, 8'h01);
    rc(sbtc_pkg::ADDR_FLAG, 32'h0, "flag ro");
    wr(sbtc_pkg::ADDR_CTRL, 8'hFC);
    rc(sbtc_pkg::ADDR_CTRL, 32'h3C, "ctrl mask");
    pchk(1'b0, 2'h3, "osc pins in");
    wr(sbtc_pkg::ADDR_CTRL, 8'h00);
    @(posedge mclk);
    pbdir <= 2'h2;
    repeat (2) @(posedge mclk);
    pchk(1'b0, 2'h2, "dir follows");
    wr(sbtc_pkg::ADDR_CNT_LO, 8'hA5);
    wr(sbtc_pkg::ADDR_CNT_HI, 8'h5A);
    rc(sbtc_pkg::ADDR_CNT_LO, 32'hA5, "lo rw");
    rc(sbtc_pkg::ADDR_CNT_HI, 32'h5A, "hi rw");
    wr(8'h18, 8'h01, sbtc_pkg::RESP_SLVERR);
    rd(8'h18);
    chk(32'(r), 32'(sbtc_pkg::RESP_SLVERR), "unmapped");
    rc(sbtc_pkg::ADDR_CLR, 32'h0, "clr reads 0");
    wstrb <= 4'h0;
    wr(sbtc_pkg::ADDR_EN, 8'h01);
    wstrb <= 4'hF;
    rc(sbtc_pkg::ADDR_EN, 32'h0, "strobe off");
    $display("t_regs done");
  endtask
  // Timer mode per prescale; count carries over, so each run also resumes
  task automatic t_timer;
    wr(sbtc_pkg::ADDR_CNT_LO, 8'h00);
    e = 8'h00;
    for (int p = 0; p < 4; p++) begin
      wr(sbtc_pkg::ADDR_CTRL, {2'h0, 2'(p), 1'b0, p[0], 2'h1});
      repeat (64 << p) @(posedge mclk);
      wr(sbtc_pkg::ADDR_CTRL, 8'h00);
      rd(sbtc_pkg::ADDR_CNT_LO);
      chk(32'(d[7:0] - e >= 8'h10 && d[7:0] - e <= 8'h12), 32'h1, "rate");
      e = d[7:0];
      repeat (40) @(posedge mclk);
      rc(sbtc_pkg::ADDR_CNT_LO, 32'(e), "hold");
    end
    $display("t_timer done");
  endtask
  task automatic t_ovf;
    wr(sbtc_pkg::ADDR_CNT_LO, 8'hFF);
    wr(sbtc_pkg::ADDR_CNT_HI, 8'hFF);
    wr(sbtc_pkg::ADDR_CTRL, 8'h01);
    repeat (16) @(posedge mclk);
    wr(sbtc_pkg::ADDR_CTRL, 8'h00);
    rc(sbtc_pkg::ADDR_CNT_HI, 32'h0, "wrap");
    rc(sbtc_pkg::ADDR_FLAG, 32'h1, "flag set");
    pchk(1'b1, 2'h0, "irq masked");
    wr(sbtc_pkg::ADDR_EN, 8'h01);
    pchk(1'b1, 2'h1, "irq on");
    wr(sbtc_pkg::ADDR_CLR, 8'h01);
    rc(sbtc_pkg::ADDR_FLAG, 32'h0, "flag clr");
    pchk(1'b1, 2'h0, "irq clr");
    $display("t_ovf done");
  endtask
  // Counter mode: edges after prescale, pin choice, sleep hold
  task automatic t_cnt;
    wr(sbtc_pkg::ADDR_CNT_LO, 8'h00);
    e = 8'h00;
    for (int p = 0; p < 4; p++) begin
      wr(sbtc_pkg::ADDR_CTRL, {2'h0, 2'(p), 1'b0, p[0], 2'h3});
      u_src.burst(1'b0, 16, 2 + p);
      u_src.burst(1'b1, 8, 2);
      wr(sbtc_pkg::ADDR_CTRL, 8'h00);
      e = e + 8'(16 >> p);
      rc(sbtc_pkg::ADDR_CNT_LO, 32'(e), "edges");
    end
    wr(sbtc_pkg::ADDR_CTRL, 8'h0B);
    u_src.burst(1'b1, 5, 2);
    u_src.burst(1'b0, 4, 2);
    wr(sbtc_pkg::ADDR_CTRL, 8'h00);
    rc(sbtc_pkg::ADDR_CNT_LO, 32'(e + 8'h05), "osc pin");
    wr(sbtc_pkg::ADDR_CTRL, 8'h03);
    sleep <= 1'b1;
    u_src.burst(1'b0, 6, 2);
    repeat (4) @(posedge mclk);  // Last edge is still in the synchroniser
    sleep <= 1'b0;
    wr(sbtc_pkg::ADDR_CTRL, 8'h00);
    rc(sbtc_pkg::ADDR_CNT_LO, 32'(e + 8'h05), "sleep hold");
    wr(sbtc_pkg::ADDR_CNT_LO, 8'h37);
    ccp <= 1'b1;
    @(posedge mclk);
    ccp <= 1'b0;
    rc(sbtc_pkg::ADDR_CNT_LO, 32'h0, "ccp clr");
    $display("t_cnt done");
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////
  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Main sequence after 20 cycles of reset
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, ccp, sleep} = 8'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    pbdir = 2'h0;
    n_mismatch = 0;
    checked = 0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    t_regs;
    t_timer;
    t_ovf;
    t_cnt;
    test_done;
  end
  // Watchdog: the run needs about 2000 cycles, so 30000 means a hang
  initial begin
    repeat (30000) @(posedge mclk);
    n_mismatch++;
    test_done;
  end
endmodule
